// [common/prif_map.svh]
// Address map, field positions, reset values and command bits of the register interface
`ifndef PRIF_MAP_SVH
`define PRIF_MAP_SVH
// Register window sizes in address bits
`define PRIF_WIN_BITS       14
`define PRIF_IRQC_WIN_BITS  12
`define PRIF_ADDR_W         14
// Register byte offsets
`define PRIF_OFS_CTRL       14'h0000
`define PRIF_OFS_MODE       14'h0004
`define PRIF_OFS_STAT       14'h0008
`define PRIF_OFS_EVT        14'h000C
`define PRIF_OFS_IEN        14'h0010
`define PRIF_OFS_IDIS       14'h0014
`define PRIF_OFS_IMASK      14'h0018
`define PRIF_OFS_CHEN       14'h0020
`define PRIF_OFS_CHDIS      14'h0024
`define PRIF_OFS_CHST       14'h0028
`define PRIF_OFS_RX_PTR     14'h0030
`define PRIF_OFS_RX_CNT     14'h0034
`define PRIF_OFS_TX_PTR     14'h0038
`define PRIF_OFS_TX_CNT     14'h003C
// Reset values
`define PRIF_RST_MODE       2'h0
`define PRIF_RST_BITS2      2'h0
`define PRIF_RST_PTR        32'h0000_0000
`define PRIF_RST_CNT        16'h0000
`define PRIF_RST_WORD       32'h0000_0000
// Field positions
`define PRIF_BIT_RX         0
`define PRIF_BIT_TX         1
`define PRIF_MODE_MSB       1
`define PRIF_CNT_MSB        15
`define PRIF_STAT_BUSY_LSB  2
`define PRIF_STAT_W         4
`define PRIF_CNT_ONE        16'h0001
`define PRIF_CNT_ZERO       16'h0000
`endif

// [common/prif_pkg.sv]
// Types and helpers shared by the register interface and its transfer channels
package prif_pkg;
    // Size of one data unit moved by a channel
    typedef enum logic [1:0] {
        PRIF_UNIT_BYTE = 2'h0,
        PRIF_UNIT_HALF = 2'h1,
        PRIF_UNIT_WORD = 2'h2,
        PRIF_UNIT_RSVD = 2'h3
    } prif_unit_t;

    // Pointer step in bytes for a unit size; reserved code steps like a byte
    function automatic logic [31:0] prif_unit_bytes(input logic [1:0] unit);
        logic [31:0] step;
        step = 32'h0000_0001;
        case (unit)
            PRIF_UNIT_HALF: step = 32'h0000_0002;
            PRIF_UNIT_WORD: step = 32'h0000_0004;
            default:        step = 32'h0000_0001;
        endcase
        return step;
    endfunction : prif_unit_bytes
endpackage : prif_pkg

// [common/prif_chan_if.sv]
// Signals between the register interface and one transfer channel
`timescale 1ns/100ps
`default_nettype none
interface prif_chan_if;
    logic        ptr_we;     // Load pointer from wdata
    logic        cnt_we;     // Load count from wdata
    logic        abort;      // Drop remaining count
    logic [31:0] wdata;      // Bus write word
    logic [1:0]  unit;       // Unit size code
    logic        enable;     // Channel enabled
    logic        periph_req; // Peripheral wants a unit moved
    logic        mem_ack;    // Memory side took the unit
    logic [31:0] ptr;        // Current address pointer
    logic [15:0] cnt;        // Units remaining
    logic        mem_req;    // Transfer request to memory side
    logic        done;       // One-cycle end of transfer pulse

    modport ctl  (output ptr_we, cnt_we, abort, wdata, unit, enable, periph_req, mem_ack,
                  input  ptr, cnt, mem_req, done);
    modport chan (input  ptr_we, cnt_we, abort, wdata, unit, enable, periph_req, mem_ack,
                  output ptr, cnt, mem_req, done);
endinterface : prif_chan_if
`default_nettype wire

// [src/prif_chan.sv]
// One peripheral transfer channel: address pointer and unit count
`timescale 1ns/100ps
`default_nettype none
`include "prif_map.svh"
module prif_chan
    import prif_pkg::*;
(
    input  wire logic  i_clk, // System clock
    input  wire logic  i_rst, // Synchronous reset, active high
    prif_chan_if.chan  cif    // Control and status toward the register file
);
    logic        step;   // A unit moves this cycle
    logic [31:0] ptr_q;  // Address pointer
    logic [15:0] cnt_q;  // Remaining units
    logic        done_q; // End pulse

    // Request only while units remain, so a finished channel goes quiet
    assign cif.mem_req = cif.enable && cif.periph_req && (cnt_q != `PRIF_CNT_ZERO);
    assign step        = cif.mem_req && cif.mem_ack;
    assign cif.ptr     = ptr_q;
    assign cif.cnt     = cnt_q;
    assign cif.done    = done_q;

    // Pointer: software load beats stepping
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ptr_q <= `PRIF_RST_PTR;
        else if (cif.ptr_we)
            ptr_q <= cif.wdata;
        else if (step)
            ptr_q <= ptr_q + prif_unit_bytes(cif.unit);
    end

    // Count: 16 bits, so one load covers up to 65535 units of the configured size
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            cnt_q <= `PRIF_RST_CNT;
        else if (cif.abort)
            cnt_q <= `PRIF_RST_CNT;
        else if (cif.cnt_we)
            cnt_q <= cif.wdata[`PRIF_CNT_MSB:0];
        else if (step)
            cnt_q <= cnt_q - `PRIF_CNT_ONE;
    end

    // End pulse once the last unit has moved
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            done_q <= 1'b0;
        else
            done_q <= step && (cnt_q == `PRIF_CNT_ONE) && !cif.cnt_we && !cif.abort;
    end

    AST_STEP_ADVANCES: assert property (@(posedge i_clk) disable iff (i_rst)
        (step && !cif.ptr_we && !cif.cnt_we && !cif.abort) |=>
        (ptr_q == $past(ptr_q) + prif_unit_bytes($past(cif.unit))) &&
        (cnt_q == $past(cnt_q) - `PRIF_CNT_ONE))
        else $error("Channel did not advance pointer and count");
    AST_IDLE_AT_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        (cnt_q == `PRIF_CNT_ZERO) |-> !cif.mem_req)
        else $error("Channel requested with zero count");
    AST_LAST_UNIT_DONE: assert property (@(posedge i_clk) disable iff (i_rst)
        (step && cnt_q == `PRIF_CNT_ONE && !cif.cnt_we && !cif.abort) |=>
        done_q && cnt_q == `PRIF_CNT_ZERO)
        else $error("No end pulse after last unit");
endmodule : prif_chan
`default_nettype wire

// [src/prif_top.sv]
// Peripheral register interface: APB slave, command/mode/status, interrupt mask, two channels
`timescale 1ns/100ps
`default_nettype none
`include "prif_map.svh"

module prif_top
    import prif_pkg::*;
#(
    parameter bit P_IRQC_WINDOW = 1'b0 // Narrow window for the interrupt controller
)
(
    input  wire logic                    I_CLK,          // 10 MHz system clock
    input  wire logic                    I_RST,          // Synchronous reset, active high
    input  wire logic                    I_PSEL,         // APB select
    input  wire logic                    I_PENABLE,      // APB access phase
    input  wire logic                    I_PWRITE,       // APB direction, high for write
    input  wire logic [`PRIF_ADDR_W-1:0] I_PADDR,        // APB byte address in window
    input  wire logic [31:0]             I_PWDATA,       // APB write data
    output logic      [31:0]             O_PRDATA,       // APB read data
    output logic                         O_PREADY,       // APB ready
    output logic                         O_PSLVERR,      // APB error, never raised
    output logic                         O_IRQ,          // Interrupt source, active high
    input  wire logic                    I_RX_REQ,       // Receiver wants a unit moved
    input  wire logic                    I_TX_REQ,       // Transmitter wants a unit moved
    output logic                         O_RX_MEM_REQ,   // Receive channel memory request
    output logic      [31:0]             O_RX_MEM_ADDR,  // Receive channel address
    input  wire logic                    I_RX_MEM_ACK,   // Receive unit taken
    output logic                         O_TX_MEM_REQ,   // Transmit channel memory request
    output logic      [31:0]             O_TX_MEM_ADDR,  // Transmit channel address
    input  wire logic                    I_TX_MEM_ACK    // Transmit unit taken
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [`PRIF_ADDR_W-1:0] addr_w;    // Word-aligned address
    logic                    in_win;    // Address inside decoded window
    logic                    setup;     // APB setup cycle
    logic                    wr;        // APB write taking effect
    logic                    rd_setup;  // Read in setup cycle
    logic [31:0]             rd_d;      // Read mux
    logic [31:0]             prdata_q;  // Registered read data
    logic [`PRIF_MODE_MSB:0] mode_q;    // Unit size configuration
    logic [1:0]              chst_q;    // Channel enable status
    logic [1:0]              imask_q;   // Interrupt mask
    logic [1:0]              evt_q;     // Sticky end-of-transfer events
    logic [1:0]              evt_d;     // Next event state
    logic [1:0]              done;      // End pulses from channels
    logic [1:0]              cnt_zero;  // Channel count is zero
    logic [`PRIF_STAT_W-1:0] stat;      // Live status word

    prif_chan_if rx_if (); // Receive channel link
    prif_chan_if tx_if (); // Transmit channel link

    // Register hit on a given offset
    function automatic logic hit(input logic [`PRIF_ADDR_W-1:0] a,
                                 input logic [`PRIF_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : hit

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Narrow accesses cannot be told apart here, so they act as whole words
    assign addr_w   = {I_PADDR[`PRIF_ADDR_W-1:2], 2'b00};
    // Bits above the window must be zero; the narrow window drops the top two
    assign in_win   = P_IRQC_WINDOW ?
                      (I_PADDR[`PRIF_WIN_BITS-1:`PRIF_IRQC_WIN_BITS] == 2'b00) : 1'b1;
    assign setup    = I_PSEL && !I_PENABLE;
    assign wr       = I_PSEL && I_PENABLE && I_PWRITE && in_win;
    assign rd_setup = setup && !I_PWRITE;

    // Zero wait states; no error even for unmapped or read-only targets
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = 1'b0;
    assign O_PRDATA  = prdata_q;

    // ------------------------------------------------------------------
    // Status assembly
    // ------------------------------------------------------------------
    assign cnt_zero = {tx_if.cnt == `PRIF_CNT_ZERO, rx_if.cnt == `PRIF_CNT_ZERO};
    assign done     = {tx_if.done, rx_if.done};
    // Low half: channel empty; high half: channel busy
    assign stat     = {chst_q & ~cnt_zero, cnt_zero};

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Unused bits and unmapped offsets return zero
    always_comb
    begin
        rd_d = `PRIF_RST_WORD;
        if (in_win)
        begin
            unique case (1'b1)
                hit(addr_w, `PRIF_OFS_MODE):
                    rd_d[`PRIF_MODE_MSB:0] = mode_q;
                hit(addr_w, `PRIF_OFS_STAT):
                    rd_d[`PRIF_STAT_W-1:0] = stat;
                hit(addr_w, `PRIF_OFS_EVT):
                    rd_d[1:0] = evt_q;
                hit(addr_w, `PRIF_OFS_IMASK):
                    rd_d[1:0] = imask_q;
                hit(addr_w, `PRIF_OFS_CHST):
                    rd_d[1:0] = chst_q;
                hit(addr_w, `PRIF_OFS_RX_PTR):
                    rd_d = rx_if.ptr;
                hit(addr_w, `PRIF_OFS_RX_CNT):
                    rd_d[`PRIF_CNT_MSB:0] = rx_if.cnt;
                hit(addr_w, `PRIF_OFS_TX_PTR):
                    rd_d = tx_if.ptr;
                hit(addr_w, `PRIF_OFS_TX_CNT):
                    rd_d[`PRIF_CNT_MSB:0] = tx_if.cnt;
                default:
                    rd_d = `PRIF_RST_WORD;
            endcase
        end
    end

    // Read data captured in setup, so it comes from a flip-flop in access
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            prdata_q <= `PRIF_RST_WORD;
        else if (rd_setup)
            prdata_q <= rd_d;
    end

    // ------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------
    // Configuration of unit size for both channels
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            mode_q <= `PRIF_RST_MODE;
        else if (wr && hit(addr_w, `PRIF_OFS_MODE))
            mode_q <= I_PWDATA[`PRIF_MODE_MSB:0];
    end

    // ------------------------------------------------------------------
    // Channel enable / disable / status
    // ------------------------------------------------------------------
    // Set and clear words avoid read-modify-write races with handlers
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            chst_q <= `PRIF_RST_BITS2;
        else if (wr && hit(addr_w, `PRIF_OFS_CHEN))
            chst_q <= chst_q | I_PWDATA[1:0];
        else if (wr && hit(addr_w, `PRIF_OFS_CHDIS))
            chst_q <= chst_q & ~I_PWDATA[1:0];
    end

    // ------------------------------------------------------------------
    // Interrupt mask enable / disable / readback
    // ------------------------------------------------------------------
    // Readback offset is never a write target; writes there fall through
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            imask_q <= `PRIF_RST_BITS2;
        else if (wr && hit(addr_w, `PRIF_OFS_IEN))
            imask_q <= imask_q | I_PWDATA[1:0];
        else if (wr && hit(addr_w, `PRIF_OFS_IDIS))
            imask_q <= imask_q & ~I_PWDATA[1:0];
    end

    // ------------------------------------------------------------------
    // Sticky events
    // ------------------------------------------------------------------
    // Write one to clear; a new end pulse in the same cycle wins
    always_comb
    begin
        evt_d = evt_q;
        if (wr && hit(addr_w, `PRIF_OFS_EVT))
            evt_d = evt_q & ~I_PWDATA[1:0];
        evt_d = evt_d | done;
    end

    // Event flags register
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            evt_q <= `PRIF_RST_BITS2;
        else
            evt_q <= evt_d;
    end

    // Single level source toward the vectored_irq_controller
    assign O_IRQ = |(evt_q & imask_q);

    // ------------------------------------------------------------------
    // Channel control
    // ------------------------------------------------------------------
    // Two of the eight system channels live here: one receive, one transmit
    assign rx_if.ptr_we     = wr && hit(addr_w, `PRIF_OFS_RX_PTR);
    assign rx_if.cnt_we     = wr && hit(addr_w, `PRIF_OFS_RX_CNT);
    assign rx_if.abort      = wr && hit(addr_w, `PRIF_OFS_CTRL) && I_PWDATA[`PRIF_BIT_RX];
    assign rx_if.wdata      = I_PWDATA;
    assign rx_if.unit       = mode_q;
    assign rx_if.enable     = chst_q[`PRIF_BIT_RX];
    assign rx_if.periph_req = I_RX_REQ;
    assign rx_if.mem_ack    = I_RX_MEM_ACK;

    assign tx_if.ptr_we     = wr && hit(addr_w, `PRIF_OFS_TX_PTR);
    assign tx_if.cnt_we     = wr && hit(addr_w, `PRIF_OFS_TX_CNT);
    assign tx_if.abort      = wr && hit(addr_w, `PRIF_OFS_CTRL) && I_PWDATA[`PRIF_BIT_TX];
    assign tx_if.wdata      = I_PWDATA;
    assign tx_if.unit       = mode_q;
    assign tx_if.enable     = chst_q[`PRIF_BIT_TX];
    assign tx_if.periph_req = I_TX_REQ;
    assign tx_if.mem_ack    = I_TX_MEM_ACK;

    assign O_RX_MEM_REQ  = rx_if.mem_req;
    assign O_RX_MEM_ADDR = rx_if.ptr;
    assign O_TX_MEM_REQ  = tx_if.mem_req;
    assign O_TX_MEM_ADDR = tx_if.ptr;

    // Receive channel
    prif_chan u_rx_chan
    (
        .i_clk (I_CLK),
        .i_rst (I_RST),
        .cif   (rx_if)
    );

    // Transmit channel
    prif_chan u_tx_chan
    (
        .i_clk (I_CLK),
        .i_rst (I_RST),
        .cif   (tx_if)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    AST_CMD_READS_ZERO: assert property (
        (rd_setup && in_win && addr_w == `PRIF_OFS_CTRL) |=> (O_PRDATA == `PRIF_RST_WORD))
        else $error("Command register read not zero");
    AST_MODE_AFTER_RESET: assert property (
        $fell(I_RST) |-> (mode_q == `PRIF_RST_MODE))
        else $error("Mode not zero after reset");
    AST_MODE_READBACK: assert property (
        (wr && addr_w == `PRIF_OFS_MODE) ##2 (rd_setup && addr_w == `PRIF_OFS_MODE && in_win) |=>
        (O_PRDATA[1:0] == $past(I_PWDATA[1:0], 3)))
        else $error("Mode readback differs from write");
    AST_STAT_READ: assert property (
        (rd_setup && in_win && addr_w == `PRIF_OFS_STAT) |=> (O_PRDATA[3:0] == $past(stat)))
        else $error("Status read wrong");
    AST_CHEN_SETS: assert property (
        (wr && addr_w == `PRIF_OFS_CHEN && I_PWDATA[0]) |=> chst_q[0])
        else $error("Enable write did not set status");
    AST_CHDIS_CLEARS: assert property (
        (wr && addr_w == `PRIF_OFS_CHDIS && I_PWDATA[1]) |=> !chst_q[1])
        else $error("Disable write did not clear status");
    AST_ZERO_NO_CHANGE: assert property (
        (wr && (addr_w == `PRIF_OFS_CHEN || addr_w == `PRIF_OFS_CHDIS) && I_PWDATA[1:0] == 2'b00) |=>
        $stable(chst_q))
        else $error("Zero write changed status");
    AST_UNUSED_ZERO: assert property (
        (rd_setup && (addr_w == `PRIF_OFS_MODE || addr_w == `PRIF_OFS_IMASK)) |=>
        (O_PRDATA[31:2] == 30'h0))
        else $error("Unused bits read nonzero");
    AST_IRQ_SOURCE: assert property (
        (evt_q[0] && imask_q[0]) || (evt_q[1] && imask_q[1]) ? O_IRQ : !O_IRQ)
        else $error("Interrupt source mismatch");
    AST_MASK_RO: assert property (
        (wr && (addr_w == `PRIF_OFS_IMASK || addr_w == `PRIF_OFS_STAT)) |=>
        $stable(imask_q) && $stable(chst_q))
        else $error("Read-only write changed state");
    AST_EVENT_SET_WINS: assert property (
        (rx_if.done) |=> evt_q[0])
        else $error("End event lost");
endmodule : prif_top
`default_nettype wire

// [testbench/prif_mem_model.sv]
// Memory-side partner that takes channel transfer requests
`timescale 1ns/100ps
`default_nettype none
module prif_mem_model (
    input  wire logic i_clk,  // System clock
    input  wire logic i_rst,  // Sync reset, active high
    input  wire logic i_slow, // Stall every other cycle
    output var  logic o_ack   // Unit taken
);
    // ----------------------------------------
    // Acknowledge generation
    // ----------------------------------------
    // Slow mode toggles so requests must wait
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_ack <= 1'b0;
        else
            o_ack <= i_slow ? ~o_ack : 1'b1;
    end
endmodule : prif_mem_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the register interface
`timescale 1ns/100ps
`default_nettype none
`include "prif_map.svh"
module tb;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    logic        clk = 1'b0;       // Bench clock
    logic        rst = 1'b1;       // Sync reset
    logic        psel = 1'b0;      // APB select
    logic        pen = 1'b0;       // APB enable
    logic        pwr = 1'b0;       // APB write
    logic [13:0] paddr = '0;       // APB address
    logic [31:0] pwdata = '0;      // APB write data
    logic [31:0] prdata;           // APB read data
    logic [31:0] rd;               // Last read
    logic        pready;           // APB ready
    logic        irq;              // Interrupt
    logic [1:0]  preq = '0;        // Peripheral requests
    logic [1:0]  slow = '0;        // Partner pace
    logic [1:0]  mreq;             // Memory requests
    logic [1:0]  ack;              // Memory acks
    logic [31:0] maddr [2];        // Memory addresses
    logic [31:0] m_ptr [2] = '{default: 32'h0000_0000};
    int          m_cnt [2] = '{default: 0};
    logic [1:0]  m_evt = '0;       // Model events
    logic [1:0]  m_mask = '0;      // Model mask
    logic [1:0]  m_en = '0;        // Model enables
    logic [1:0]  m_mode = '0;      // Model unit size
    logic [15:0] seed = 16'h6B62;  // LFSR state
    int          fail_count = 0;   // Mismatches
    int          n_checks = 0;     // Comparisons
    int          cycles = 0;       // Timeout counter

    always #50 clk = ~clk;

    prif_top prif_top_inst (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(), .O_IRQ(irq), .I_RX_REQ(preq[0]),
        .I_TX_REQ(preq[1]), .O_RX_MEM_REQ(mreq[0]), .O_RX_MEM_ADDR(maddr[0]),
        .I_RX_MEM_ACK(ack[0]), .O_TX_MEM_REQ(mreq[1]), .O_TX_MEM_ADDR(maddr[1]),
        .I_TX_MEM_ACK(ack[1]));

    for (genvar g = 0; g < 2; g++)
    begin : g_mem
        prif_mem_model prif_mem_model_inst (.i_clk(clk), .i_rst(rst), .i_slow(slow[g]),
            .o_ack(ack[g]));
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Pointer step; the spare code steps like a byte
    function automatic logic [31:0] step(input logic [1:0] u);
        return (u == 2'h1) ? 32'h0000_0002 : (u == 2'h2) ? 32'h0000_0004 : 32'h0000_0001;
    endfunction : step

    function automatic logic [31:0] exp_rd(input logic [13:0] a);
        case (a & 14'h3FFC)
            `PRIF_OFS_MODE:   return {30'h0, m_mode};
            `PRIF_OFS_STAT:   return {28'h0, m_en[1] && m_cnt[1] != 0, m_en[0] && m_cnt[0] != 0,
                                      m_cnt[1] == 0, m_cnt[0] == 0};
            `PRIF_OFS_EVT:    return {30'h0, m_evt};
            `PRIF_OFS_IMASK:  return {30'h0, m_mask};
            `PRIF_OFS_CHST:   return {30'h0, m_en};
            `PRIF_OFS_RX_PTR: return m_ptr[0];
            `PRIF_OFS_RX_CNT: return {16'h0, m_cnt[0][15:0]};
            `PRIF_OFS_TX_PTR: return m_ptr[1];
            `PRIF_OFS_TX_CNT: return {16'h0, m_cnt[1][15:0]};
            default:          return 32'h0000_0000;
        endcase
    endfunction : exp_rd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until ready is sampled high
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    // Write and update the model; low address bits are dropped
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a & 14'h3FFC)
            `PRIF_OFS_CTRL:
            begin
                m_cnt[0] = d[0] ? 0 : m_cnt[0];
                m_cnt[1] = d[1] ? 0 : m_cnt[1];
            end
            `PRIF_OFS_MODE:   m_mode = d[1:0];
            `PRIF_OFS_EVT:    m_evt &= ~d[1:0];
            `PRIF_OFS_IEN:    m_mask |= d[1:0];
            `PRIF_OFS_IDIS:   m_mask &= ~d[1:0];
            `PRIF_OFS_CHEN:   m_en |= d[1:0];
            `PRIF_OFS_CHDIS:  m_en &= ~d[1:0];
            `PRIF_OFS_RX_PTR: m_ptr[0] = d;
            `PRIF_OFS_RX_CNT: m_cnt[0] = d[15:0];
            `PRIF_OFS_TX_PTR: m_ptr[1] = d;
            `PRIF_OFS_TX_CNT: m_cnt[1] = d[15:0];
            default:          ;
        endcase
    endtask : wr

    task automatic rdchk(input logic [13:0] a);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp_rd(a), "register read");
    endtask : rdchk

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Transfer monitor and timeout
    // ----------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
        else
        for (int c = 0; c < 2; c++)
            if (!rst && mreq[c] === 1'b1 && ack[c] === 1'b1)
            begin
                chk(maddr[c], m_ptr[c], "transfer address");
                chk(32'(m_cnt[c] != 0), 32'h0000_0001, "request at zero");
                m_ptr[c] = m_ptr[c] + step(m_mode);
                m_cnt[c] = m_cnt[c] - 1;
                if (m_cnt[c] == 0)
                    m_evt[c] = 1'b1;
            end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 68; a += 4)
            rdchk(14'(a));
        $display("test reset done");
        seed = lfsr(seed);
        wr(`PRIF_OFS_MODE + 14'h2, {30'h0, seed[1:0]});
        rdchk(`PRIF_OFS_MODE);
        wr(`PRIF_OFS_STAT, 32'h0000_000F);
        wr(`PRIF_OFS_IMASK, 32'h0000_0003);
        wr(`PRIF_OFS_CHST, 32'h0000_0003);
        wr(14'h0040, 32'h0000_0003);
        rdchk(`PRIF_OFS_STAT);
        rdchk(`PRIF_OFS_IMASK);
        rdchk(`PRIF_OFS_CHST);
        rdchk(14'h0040);
        wr(`PRIF_OFS_IEN, 32'h0000_0003);
        wr(`PRIF_OFS_IDIS, 32'h0000_0001);
        wr(`PRIF_OFS_IEN, 32'h0000_0000);
        rdchk(`PRIF_OFS_IMASK);
        wr(`PRIF_OFS_CHEN, 32'h0000_0002);
        wr(`PRIF_OFS_CHDIS, 32'h0000_0000);
        rdchk(`PRIF_OFS_CHST);
        wr(`PRIF_OFS_CHDIS, 32'h0000_0002);
        rdchk(`PRIF_OFS_CHST);
        wr(`PRIF_OFS_RX_CNT, 32'h0000_FFFF);
        rdchk(`PRIF_OFS_RX_CNT);
        wr(`PRIF_OFS_CTRL, 32'h0000_0001);
        rdchk(`PRIF_OFS_RX_CNT);
        rdchk(`PRIF_OFS_CTRL);
        wr(`PRIF_OFS_TX_CNT, 32'h0000_0005);
        wr(`PRIF_OFS_CTRL, 32'h0000_0002);
        rdchk(`PRIF_OFS_TX_CNT);
        wr(`PRIF_OFS_EVT, 32'h0000_0003);
        wr(`PRIF_OFS_IDIS, 32'h0000_0003);
        wr(`PRIF_OFS_IEN, 32'h0000_0001);
        $display("test registers done");
        // Every unit size on both channels, one unit on receive and three on transmit
        for (int u = 0; u < 4; u++)
            for (int c = 0; c < 2; c++)
            begin
                seed = lfsr(seed);
                slow <= 2'(u);
                wr(`PRIF_OFS_MODE, 32'(u));
                wr(`PRIF_OFS_RX_PTR + 14'(8 * c), {seed, lfsr(seed)});
                wr(`PRIF_OFS_RX_CNT + 14'(8 * c), 32'(1 + 2 * c));
                wr(`PRIF_OFS_CHEN, 32'(1 << c));
                preq[c] <= 1'b1;
                rd = '0;
                while (rd[c] !== 1'b1)
                    apb(1'b0, `PRIF_OFS_STAT, 32'h0000_0000);
                preq[c] <= 1'b0;
                rdchk(`PRIF_OFS_EVT);
                rdchk(`PRIF_OFS_RX_PTR + 14'(8 * c));
                rdchk(`PRIF_OFS_STAT);
                @(negedge clk);
                chk(32'(irq), 32'(|(m_evt & m_mask)), "interrupt level");
                wr(`PRIF_OFS_EVT, 32'h0000_0003);
                wr(`PRIF_OFS_CHDIS, 32'h0000_0003);
                @(negedge clk);
                chk(32'(irq), 32'h0000_0000, "interrupt cleared");
            end
        $display("test transfers done");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
